// *** include/tsf_defines.svh ***
`ifndef TSF_DEFINES_SVH
`define TSF_DEFINES_SVH

// Register byte offsets
`define TSF_OFF_CONTROL    8'h00
`define TSF_OFF_IRQ_EN     8'h0C
`define TSF_OFF_STATUS     8'h10
`define TSF_OFF_EVGEN      8'h14
`define TSF_OFF_CH1        8'h34
`define TSF_OFF_CH2        8'h38

// Status, interrupt enable and event generation bit positions
`define TSF_B_UPD          0
`define TSF_B_CH1          1
`define TSF_B_CH2          2
`define TSF_B_TRG          6
`define TSF_B_RC1          9
`define TSF_B_RC2          10

// Control bit positions
`define TSF_B_UD           1
`define TSF_B_UPDATE_SOURCE_SELECT        2
`define TSF_B_CH1_IN       8
`define TSF_B_CH2_IN       9

// Implemented bits of each register
`define TSF_STATUS_MASK    16'h0647
`define TSF_IRQ_EN_MASK    16'h0047
`define TSF_CONTROL_MASK   16'h0306

// Reset values
`define TSF_RST_REG        16'h0000
`define TSF_RST_WORD       32'h0000_0000

// Only whole-word transfers are accepted
`define TSF_HSIZE_WORD     3'h2

`endif

// *** include/tsf_pkg.sv ***
package tsf_pkg;

   typedef logic [15:0] tsf_reg_t;

   // Events and count coming from the timer core
   typedef struct packed {
      logic       overflow;
      logic       trig_reinit;
      logic       trigger;
      logic [1:0] capture;
      tsf_reg_t   counter;
   } tsf_timer_in_s;

   typedef struct packed {
      tsf_reg_t    control;
      tsf_reg_t    irq_enable;
      tsf_reg_t    status;
      logic        dph_valid;
      logic        dph_write;
      logic [7:0]  dph_addr;
      logic [31:0] rdata;
      logic        irq;
      logic        reinit;
      logic        update_event;
   } tsf_top_state_s;

   typedef struct packed {
      tsf_reg_t value;
      logic     prev_match;
   } tsf_ch_state_s;

endpackage

// *** core/tsf_channel.sv ***
`timescale 1ns/1ns
`include "tsf_defines.svh"

module tsf_channel
   import tsf_pkg::*;
(
   // Clock and reset
   input  wire logic     clock,
   input  wire logic     rstn,
   // Channel configuration and timer events
   input  wire logic     is_input,
   input  wire tsf_reg_t counter,
   input  wire logic     capture,
   input  wire logic     soft_event,
   // Register access
   input  wire logic     wr_en,
   input  wire tsf_reg_t wr_data,
   input  wire logic     flag_now,
   // Results
   output tsf_reg_t      value,
   output tsf_reg_t      value_next,
   output logic          flag_set,
   output logic          repeat_set
);

   tsf_ch_state_s st;
   tsf_ch_state_s next_st;
   logic          match;
   logic          cap;

   always_comb begin
      next_st = st;
      match   = !is_input && (counter == st.value);
      cap     = is_input && (capture || soft_event);
      // Compare value is software-owned only in output mode
      if (wr_en && !is_input) begin
         next_st.value = wr_data;
      end
      if (cap) begin
         next_st.value = counter;
      end
      next_st.prev_match = match;
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign value      = st.value;
   assign value_next = next_st.value;
   // Match is taken on its first cycle so a stalled counter does not refire
   assign flag_set   = (match && !st.prev_match) || cap || (soft_event && !is_input);
   assign repeat_set = cap && flag_now;

   match_sets_a : assert property (@(posedge clock) disable iff (!rstn)
      (!is_input && counter == st.value && !st.prev_match) |-> flag_set)
      else $error("compare match did not raise the channel flag");

   capture_store_a : assert property (@(posedge clock) disable iff (!rstn)
      (is_input && capture) |-> flag_set ##1 (st.value == $past(counter)))
      else $error("capture did not store the counter");

   repeat_only_in_a : assert property (@(posedge clock) disable iff (!rstn)
      repeat_set |-> (is_input && flag_now))
      else $error("repeat capture raised outside input capture");

endmodule

// *** core/tsf_status_flags.sv ***
`timescale 1ns/1ns
`include "tsf_defines.svh"

// Functional notes
// - Update flag in bit 0 is set on every update event and stays set.
// - With update disable at 0, overflow or underflow makes an update event.
// - With select and disable both 0, writing update generate makes an update.
// - With select and disable both 0, trigger reinitialisation makes an update.
// - Output channel 1 sets bit 1 when counter equals compare value.
// - Input channel 1 sets bit 1 when a capture stores the counter.
// - Channel 1 flag clears on a write of 0 or a capture register read.
// - Channel 2 flag in bit 2 behaves like channel 1.
// - Trigger flag in bit 6 is set on trigger events and stays set.
// - Input capture while channel 1 flag set raises repeat flag bit 9.
// - Channel 2 repeat flag in bit 10 behaves like channel 1's.
// - Interrupt is raised while a flag and its enable bit are both set.
// - Update generate reinitialises the counter and clears itself by hardware.

module tsf_status_flags
   import tsf_pkg::*;
(
   // Clock and reset
   input  wire logic          clock,
   input  wire logic          rstn,
   // AHB-Lite slave
   input  wire logic          hsel,
   input  wire logic [31:0]   haddr,
   input  wire logic [1:0]    htrans,
   input  wire logic          hwrite,
   input  wire logic [2:0]    hsize,
   input  wire logic [31:0]   hwdata,
   input  wire logic          hready,
   output logic               hreadyout,
   output logic               hresp,
   output logic [31:0]        hrdata,
   // Timer core
   input  wire tsf_timer_in_s timer_in,
   output logic               counter_reinit,
   output logic               update_event,
   output tsf_reg_t           ch1_compare_capture_value,
   output tsf_reg_t           ch2_compare_capture_value,
   // Interrupt
   output logic               irq
);

   localparam logic [7:0] CH_OFF [2] = '{`TSF_OFF_CH1, `TSF_OFF_CH2};

   tsf_top_state_s st;
   tsf_top_state_s next_st;

   logic           wr;
   logic           take;
   logic           rd_take;
   logic           ug;
   logic           teg;
   logic           upd_set;
   logic           trg_set;
   logic [1:0]     ch_input;
   logic [1:0]     ch_soft;
   logic [1:0]     ch_wr;
   logic [1:0]     ch_flag_set;
   logic [1:0]     ch_rep_set;
   tsf_reg_t       ch_value      [2];
   tsf_reg_t       ch_value_next [2];

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
      hit = (addr == off);
   endfunction

   function automatic tsf_reg_t rd_mux(input logic [7:0] addr,
                                       input tsf_reg_t   ctrl,
                                       input tsf_reg_t   ien,
                                       input tsf_reg_t   sts,
                                       input tsf_reg_t   v1,
                                       input tsf_reg_t   v2);
      rd_mux = `TSF_RST_REG;
      if (hit(addr, `TSF_OFF_CONTROL)) begin
         rd_mux = ctrl;
      end
      if (hit(addr, `TSF_OFF_IRQ_EN)) begin
         rd_mux = ien;
      end
      if (hit(addr, `TSF_OFF_STATUS)) begin
         rd_mux = sts & `TSF_STATUS_MASK;
      end
      if (hit(addr, `TSF_OFF_CH1)) begin
         rd_mux = v1;
      end
      if (hit(addr, `TSF_OFF_CH2)) begin
         rd_mux = v2;
      end
   endfunction

   // Bus phase decode
   assign take    = hsel && hready && htrans[1] && (hsize == `TSF_HSIZE_WORD);
   assign rd_take = take && !hwrite;
   assign wr      = st.dph_valid && st.dph_write;

   // Event generation register is write-only; its bits act for one cycle
   assign ug  = wr && hit(st.dph_addr, `TSF_OFF_EVGEN) && hwdata[`TSF_B_UPD];
   assign teg = wr && hit(st.dph_addr, `TSF_OFF_EVGEN) && hwdata[`TSF_B_TRG];

   assign upd_set = (timer_in.overflow && !st.control[`TSF_B_UD])
                 || ((ug || timer_in.trig_reinit)
                     && !st.control[`TSF_B_UD] && !st.control[`TSF_B_UPDATE_SOURCE_SELECT]);
   assign trg_set = timer_in.trigger || teg;

   assign ch_input = st.control[`TSF_B_CH2_IN:`TSF_B_CH1_IN];

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_ch
         assign ch_soft[g] = wr && hit(st.dph_addr, `TSF_OFF_EVGEN)
                          && hwdata[`TSF_B_CH1 + g];
         assign ch_wr[g]   = wr && hit(st.dph_addr, CH_OFF[g]);

         tsf_channel u_ch (
            .clock      (clock),
            .rstn       (rstn),
            .is_input   (ch_input[g]),
            .counter    (timer_in.counter),
            .capture    (timer_in.capture[g]),
            .soft_event (ch_soft[g]),
            .wr_en      (ch_wr[g]),
            .wr_data    (hwdata[15:0]),
            .flag_now   (st.status[`TSF_B_CH1 + g]),
            .value      (ch_value[g]),
            .value_next (ch_value_next[g]),
            .flag_set   (ch_flag_set[g]),
            .repeat_set (ch_rep_set[g])
         );
      end
   endgenerate

   always_comb begin
      next_st = st;

      if (wr && hit(st.dph_addr, `TSF_OFF_CONTROL)) begin
         next_st.control = hwdata[15:0] & `TSF_CONTROL_MASK;
      end
      if (wr && hit(st.dph_addr, `TSF_OFF_IRQ_EN)) begin
         next_st.irq_enable = hwdata[15:0] & `TSF_IRQ_EN_MASK;
      end

      // A written 0 clears, a written 1 keeps; reserved bits stay 0
      if (wr && hit(st.dph_addr, `TSF_OFF_STATUS)) begin
         next_st.status = st.status & hwdata[15:0] & `TSF_STATUS_MASK;
      end

      // Reading a capture register clears its channel flag
      for (int i = 0; i < 2; i++) begin
         if (rd_take && hit(haddr[7:0], CH_OFF[i])) begin
            next_st.status[`TSF_B_CH1 + i] = 1'b0;
         end
      end

      // Hardware sets come last so they win over any clear
      if (upd_set) begin
         next_st.status[`TSF_B_UPD] = 1'b1;
      end
      if (trg_set) begin
         next_st.status[`TSF_B_TRG] = 1'b1;
      end
      for (int i = 0; i < 2; i++) begin
         if (ch_flag_set[i]) begin
            next_st.status[`TSF_B_CH1 + i] = 1'b1;
         end
         if (ch_rep_set[i]) begin
            next_st.status[`TSF_B_RC1 + i] = 1'b1;
         end
      end

      next_st.irq          = |(next_st.status & next_st.irq_enable);
      next_st.reinit       = ug;
      next_st.update_event = upd_set;

      next_st.dph_valid = take;
      next_st.dph_write = hwrite;
      next_st.dph_addr  = haddr[7:0];

      // Read data come from the post-update values, so a read right after
      // a write returns the written data
      next_st.rdata = `TSF_RST_WORD;
      if (rd_take) begin
         next_st.rdata = {16'h0000, rd_mux(haddr[7:0], next_st.control,
                                           next_st.irq_enable, next_st.status,
                                           ch_value_next[0], ch_value_next[1])};
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign hreadyout                 = 1'b1;
   assign hresp                     = 1'b0;
   assign hrdata                    = st.rdata;
   assign counter_reinit            = st.reinit;
   assign update_event              = st.update_event;
   assign ch1_compare_capture_value = ch_value[0];
   assign ch2_compare_capture_value = ch_value[1];
   assign irq                       = st.irq;

   // Checks

   upd_hold_a : assert property (@(posedge clock) disable iff (!rstn)
      (st.status[`TSF_B_UPD] && !(wr && hit(st.dph_addr, `TSF_OFF_STATUS)))
      |=> st.status[`TSF_B_UPD])
      else $error("update flag dropped without a clear");

   overflow_upd_a : assert property (@(posedge clock) disable iff (!rstn)
      (timer_in.overflow && !st.control[`TSF_B_UD]) |=> st.status[`TSF_B_UPD] && update_event)
      else $error("overflow did not set the update flag");

   ug_update_a : assert property (@(posedge clock) disable iff (!rstn)
      (ug && !st.control[`TSF_B_UD] && !st.control[`TSF_B_UPDATE_SOURCE_SELECT])
      |=> st.status[`TSF_B_UPD])
      else $error("update generate did not set the update flag");

   disabled_upd_a : assert property (@(posedge clock) disable iff (!rstn)
      (st.control[`TSF_B_UD] && !st.status[`TSF_B_UPD]) |=> !update_event)
      else $error("update event while updates disabled");

   trig_reinit_a : assert property (@(posedge clock) disable iff (!rstn)
      (timer_in.trig_reinit && st.control[2:1] == 2'b00) |=> st.status[`TSF_B_UPD])
      else $error("trigger reinit did not set the update flag");

   ch_read_clr_a : assert property (@(posedge clock) disable iff (!rstn)
      (rd_take && hit(haddr[7:0], `TSF_OFF_CH1) && !ch_flag_set[0])
      |=> !st.status[`TSF_B_CH1])
      else $error("capture register read did not clear the flag");

   trig_flag_a : assert property (@(posedge clock) disable iff (!rstn)
      timer_in.trigger |=> st.status[`TSF_B_TRG] ##1 $stable(st.status[`TSF_B_TRG])
         || $past(wr))
      else $error("trigger did not set the trigger flag");

   irq_follows_a : assert property (@(posedge clock) disable iff (!rstn)
      (|(st.status & st.irq_enable)) && $stable(st.status) && $stable(st.irq_enable)
      |-> irq)
      else $error("interrupt low while an enabled flag is set");

   reinit_pulse_a : assert property (@(posedge clock) disable iff (!rstn)
      (ug && !$past(ug)) |=> counter_reinit ##1 (!counter_reinit || $past(ug)))
      else $error("reinit pulse wrong");

   w1_keeps_a : assert property (@(posedge clock) disable iff (!rstn)
      (wr && hit(st.dph_addr, `TSF_OFF_STATUS) && hwdata[`TSF_B_CH1]
       && st.status[`TSF_B_CH1] && !rd_take) |=> st.status[`TSF_B_CH1])
      else $error("writing one cleared a flag");

   set_wins_a : assert property (@(posedge clock) disable iff (!rstn)
      (wr && hit(st.dph_addr, `TSF_OFF_STATUS) && !hwdata[`TSF_B_TRG] && trg_set)
      |=> st.status[`TSF_B_TRG])
      else $error("clear beat a hardware set");

   rsvd_zero_a : assert property (@(posedge clock) disable iff (!rstn)
      (st.status & ~`TSF_STATUS_MASK) == 16'h0000)
      else $error("reserved status bit set");

   // Stickiness, set and clear causes, update gating, reserved reads and interrupt sources

   trg_hold_a : assert property (@(posedge clock) disable iff (!rstn)
      (st.status[`TSF_B_TRG] && !(wr && hit(st.dph_addr, `TSF_OFF_STATUS)))
      |=> st.status[`TSF_B_TRG])
      else $error("trigger flag dropped without a clear");

   teg_sets_a : assert property (@(posedge clock) disable iff (!rstn)
      teg |=> st.status[`TSF_B_TRG])
      else $error("trigger generate did not set the trigger flag");

   ch1_hold_a : assert property (@(posedge clock) disable iff (!rstn)
      (st.status[`TSF_B_CH1] && !(wr && hit(st.dph_addr, `TSF_OFF_STATUS))
       && !(rd_take && hit(haddr[7:0], `TSF_OFF_CH1))) |=> st.status[`TSF_B_CH1])
      else $error("channel 1 flag dropped without a clear");

   ch2_read_clr_a : assert property (@(posedge clock) disable iff (!rstn)
      (rd_take && hit(haddr[7:0], `TSF_OFF_CH2) && !ch_flag_set[1])
      |=> !st.status[`TSF_B_CH2])
      else $error("channel 2 value read did not clear the flag");

   ch1_set_a : assert property (@(posedge clock) disable iff (!rstn)
      ch_flag_set[0] |=> st.status[`TSF_B_CH1])
      else $error("channel 1 event did not set the flag");

   ch2_set_a : assert property (@(posedge clock) disable iff (!rstn)
      ch_flag_set[1] |=> st.status[`TSF_B_CH2])
      else $error("channel 2 event did not set the flag");

   rep1_set_a : assert property (@(posedge clock) disable iff (!rstn)
      ch_rep_set[0] |=> st.status[`TSF_B_RC1])
      else $error("channel 1 repeat capture did not set the flag");

   rep1_cause_a : assert property (@(posedge clock) disable iff (!rstn)
      $rose(st.status[`TSF_B_RC1])
      |-> ($past(st.status[`TSF_B_CH1]) && $past(ch_input[0])))
      else $error("channel 1 repeat flag set without a pending capture");

   rep2_cause_a : assert property (@(posedge clock) disable iff (!rstn)
      $rose(st.status[`TSF_B_RC2])
      |-> ($past(st.status[`TSF_B_CH2]) && $past(ch_input[1])))
      else $error("channel 2 repeat flag set without a pending capture");

   rep1_hold_a : assert property (@(posedge clock) disable iff (!rstn)
      (st.status[`TSF_B_RC1] && !(wr && hit(st.dph_addr, `TSF_OFF_STATUS)))
      |=> st.status[`TSF_B_RC1])
      else $error("channel 1 repeat flag dropped without a clear");

   irq_source_a : assert property (@(posedge clock) disable iff (!rstn)
      irq |-> (|(st.status & `TSF_IRQ_EN_MASK)))
      else $error("interrupt raised by a flag without an enable bit");

   irq_low_a : assert property (@(posedge clock) disable iff (!rstn)
      !(|(st.status & st.irq_enable)) |-> !irq)
      else $error("interrupt high with no enabled flag set");

   ud_blocks_a : assert property (@(posedge clock) disable iff (!rstn)
      st.control[`TSF_B_UD] |=> !update_event)
      else $error("update event while update disable is set");

   update_source_select_blocks_a : assert property (@(posedge clock) disable iff (!rstn)
      (st.control[`TSF_B_UPDATE_SOURCE_SELECT] && !timer_in.overflow) |=> !update_event)
      else $error("update event from a source that select excludes");

   reinit_cause_a : assert property (@(posedge clock) disable iff (!rstn)
      counter_reinit |-> $past(ug))
      else $error("counter reinit without an update generate write");

   rsvd_read_a : assert property (@(posedge clock) disable iff (!rstn)
      (rd_take && hit(haddr[7:0], `TSF_OFF_STATUS))
      |=> ((hrdata & 32'hFFFF_F9B8) == 32'h0000_0000))
      else $error("status read returned a reserved bit");

   upd_cause_a : assert property (@(posedge clock) disable iff (!rstn)
      $rose(st.status[`TSF_B_UPD]) |-> $past(upd_set))
      else $error("update flag set without an update event");

endmodule

// *** testbench/tb.sv ***
`timescale 1ns/1ns
`include "tsf_defines.svh"

module tb
   import tsf_pkg::*;
;
   typedef struct packed {
      tsf_reg_t   ctrl;
      tsf_reg_t   ien;
      logic [3:0] kind;
      logic [1:0] cnt;
      tsf_reg_t   sts;
      logic       irq;
   } tsf_row_s;

   logic          clock  = 1'b0;
   logic          rstn   = 1'b0;
   logic          hsel   = 1'b0;
   logic [31:0]   haddr  = 32'h0000_0000;
   logic [1:0]    htrans = 2'b00;
   logic          hwrite = 1'b0;
   logic [2:0]    hsize  = `TSF_HSIZE_WORD;
   logic [31:0]   hwdata = 32'h0000_0000;
   tsf_timer_in_s ti     = {1'b0, 1'b0, 1'b0, 2'b00, 16'h5555};
   wire           hready;
   wire           hresp;
   wire [31:0]    hrdata;
   wire           counter_reinit;
   wire           update_event;
   wire tsf_reg_t ch1_v;
   wire tsf_reg_t ch2_v;
   wire           irq;
   int            n_mismatch = 0;
   int            compares = 0;
   int            cycles = 0;
   logic [31:0]   rd_val;

   // Ordinary cases: control, enables, event kind, repeats, expected status and interrupt
   tsf_row_s rows [0:12] = '{
      '{16'h0000, 16'h0001, 4'h0, 2'h1, 16'h0001, 1'b1},
      '{16'h0002, 16'h0001, 4'h0, 2'h1, 16'h0000, 1'b0},
      '{16'h0000, 16'h0000, 4'h5, 2'h1, 16'h0001, 1'b0},
      '{16'h0004, 16'h0001, 4'h5, 2'h1, 16'h0000, 1'b0},
      '{16'h0000, 16'h0041, 4'h1, 2'h1, 16'h0001, 1'b1},
      '{16'h0004, 16'h0001, 4'h1, 2'h1, 16'h0000, 1'b0},
      '{16'h0000, 16'h0040, 4'h2, 2'h1, 16'h0040, 1'b1},
      '{16'h0000, 16'h0040, 4'h6, 2'h1, 16'h0040, 1'b1},
      '{16'h0000, 16'h0002, 4'h7, 2'h1, 16'h0002, 1'b1},
      '{16'h0100, 16'h0002, 4'h3, 2'h1, 16'h0002, 1'b1},
      '{16'h0100, 16'h0002, 4'h3, 2'h2, 16'h0202, 1'b1},
      '{16'h0300, 16'h0004, 4'h4, 2'h2, 16'h0404, 1'b1},
      '{16'h0300, 16'h0006, 4'hA, 2'h2, 16'h0606, 1'b1}
   };

   tsf_status_flags dut (
      .clock                     (clock),
      .rstn                      (rstn),
      .hsel                      (hsel),
      .haddr                     (haddr),
      .htrans                    (htrans),
      .hwrite                    (hwrite),
      .hsize                     (hsize),
      .hwdata                    (hwdata),
      .hready                    (hready),
      .hreadyout                 (hready),
      .hresp                     (hresp),
      .hrdata                    (hrdata),
      .timer_in                  (ti),
      .counter_reinit            (counter_reinit),
      .update_event              (update_event),
      .ch1_compare_capture_value (ch1_v),
      .ch2_compare_capture_value (ch2_v),
      .irq                       (irq)
   );

   always #5 clock = ~clock;

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One single word transfer; ovf raises an overflow pulse during the data phase
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      input logic ovf);
      hsel   <= 1'b1;
      haddr  <= {24'h00_0000, a};
      htrans <= 2'b10;
      hwrite <= wr;
      hsize  <= `TSF_HSIZE_WORD;
      do @(posedge clock); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      if (ovf) begin
         ti.overflow <= 1'b1;
      end
      do @(posedge clock); while (hready !== 1'b1);
      rd_val = hrdata;
      if (ovf) begin
         ti.overflow <= 1'b0;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 1'b0);
   endtask

   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000, 1'b0);
      chk(nm, rd_val, e);
   endtask

   // One timer event pulse, then the inputs return to idle
   task automatic pulse(input logic [3:0] k);
      case (k)
         4'h0: ti.overflow <= 1'b1;
         4'h1: ti.trig_reinit <= 1'b1;
         4'h2: ti.trigger <= 1'b1;
         4'h3: ti.capture <= 2'b01;
         4'h4: ti.capture <= 2'b10;
         4'h8: ti <= {1'b0, 1'b0, 1'b0, 2'b01, 16'h2222};
         4'h9: ti <= {1'b0, 1'b0, 1'b0, 2'b10, 16'h3333};
         default: ti.counter <= 16'h1234;
      endcase
      @(posedge clock);
      ti <= {1'b0, 1'b0, 1'b0, 2'b00, 16'h5555};
      @(posedge clock);
   endtask

   task automatic ev(input logic [3:0] k);
      if (k == 4'h5) begin
         wr(`TSF_OFF_EVGEN, 32'h0000_0001);
      end else if (k == 4'h6) begin
         wr(`TSF_OFF_EVGEN, 32'h0000_0040);
      end else if (k == 4'hA) begin
         wr(`TSF_OFF_EVGEN, 32'h0000_0006);
      end else begin
         if (k == 4'h7) begin
            wr(`TSF_OFF_CH1, 32'h0000_1234);
         end
         pulse(k);
      end
   endtask

   initial begin
      repeat (20) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      rchk("status reset", `TSF_OFF_STATUS, `TSF_RST_WORD);
      foreach (rows[i]) begin
         wr(`TSF_OFF_CONTROL, {16'h0000, rows[i].ctrl});
         wr(`TSF_OFF_IRQ_EN, {16'h0000, rows[i].ien});
         wr(`TSF_OFF_STATUS, 32'h0000_0000);
         for (int n = 0; n < rows[i].cnt; n++) begin
            ev(rows[i].kind);
         end
         rchk("row status", `TSF_OFF_STATUS, {16'h0000, rows[i].sts});
         chk("row irq", {31'h0, irq}, {31'h0, rows[i].irq});
      end
      // Write one keeps, reserved bits stay zero, hardware set beats a clear
      wr(`TSF_OFF_STATUS, 32'h0000_0000);
      pulse(4'h0);
      wr(`TSF_OFF_STATUS, 32'h0000_FFFF);
      rchk("write one keeps", `TSF_OFF_STATUS, 32'h0000_0001);
      wr(`TSF_OFF_STATUS, 32'h0000_0000);
      bus(1'b1, `TSF_OFF_STATUS, 32'h0000_0000, 1'b1);
      rchk("set beats clear", `TSF_OFF_STATUS, 32'h0000_0001);
      wr(`TSF_OFF_STATUS, 32'h0000_0000);
      rchk("write zero clears", `TSF_OFF_STATUS, 32'h0000_0000);
      // Capture value read clears the channel flag
      pulse(4'h8);
      chk("ch1 captured", {16'h0000, ch1_v}, 32'h0000_2222);
      rchk("ch1 value read", `TSF_OFF_CH1, 32'h0000_2222);
      rchk("ch1 read clears", `TSF_OFF_STATUS, 32'h0000_0000);
      pulse(4'h9);
      chk("ch2 captured", {16'h0000, ch2_v}, 32'h0000_3333);
      rchk("ch2 value read", `TSF_OFF_CH2, 32'h0000_3333);
      rchk("ch2 read clears", `TSF_OFF_STATUS, 32'h0000_0000);
      // Update generate pulses once and clears itself
      wr(`TSF_OFF_EVGEN, 32'h0000_0001);
      #1;
      chk("reinit pulse", {31'h0, counter_reinit}, 32'h0000_0001);
      chk("update pulse", {31'h0, update_event}, 32'h0000_0001);
      @(posedge clock);
      #1;
      chk("reinit ends", {31'h0, counter_reinit}, 32'h0000_0000);
      chk("update ends", {31'h0, update_event}, 32'h0000_0000);
      rchk("evgen reads zero", `TSF_OFF_EVGEN, 32'h0000_0000);
      rchk("flag from generate", `TSF_OFF_STATUS, 32'h0000_0001);
      // Interrupt masking and unmapped space
      wr(`TSF_OFF_STATUS, 32'h0000_0000);
      wr(`TSF_OFF_IRQ_EN, 32'h0000_FFFF);
      rchk("irq enable bits", `TSF_OFF_IRQ_EN, 32'h0000_0047);
      pulse(4'h2);
      @(posedge clock);
      chk("irq raised", {31'h0, irq}, 32'h0000_0001);
      wr(`TSF_OFF_IRQ_EN, 32'h0000_0000);
      repeat (2) @(posedge clock);
      chk("irq masked", {31'h0, irq}, 32'h0000_0000);
      rchk("flag still set", `TSF_OFF_STATUS, 32'h0000_0040);
      rchk("unmapped read", 8'h20, 32'h0000_0000);
      chk("bus response", {31'h0, hresp}, 32'h0000_0000);
      // Reset in mid-run clears the flags
      rstn <= 1'b0;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      rchk("status after reset", `TSF_OFF_STATUS, `TSF_RST_WORD);
      give_verdict();
   end
endmodule
